// ==== design/pceirq_top.sv ====
// Pin change interrupt block: edge detect, flags, register port, interrupt
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module pceirq_top
	import pceirq_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// Monitored pins
	input wire logic [5:0] port_a_pin_i,
	input wire logic [7:4] port_b_pin_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Interrupt and wake
	output logic change_irq_o,
	output logic wake_o,
	output logic irq_o
);
	//------------------------------------------------------------
	// Edge detect helper
	//------------------------------------------------------------
	// Flag request from enables and previous/current sample
	function automatic logic [7:0] edge_hits(input logic [7:0] cur, input logic [7:0] old,
		input logic [7:0] rise, input logic [7:0] fall);
		edge_hits = (rise & cur & ~old) | (fall & ~cur & old);
	endfunction

	pceirq_bus_type bus;
	pceirq_state_type state_reg;
	pceirq_state_type state_next;
	logic [7:0] a_hit;
	logic [7:0] b_hit;
	logic summary;

	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		// Two-flop synchroniser then edge history
		state_next.a_sync1 = {2'h0, port_a_pin_i};
		state_next.b_sync1 = {port_b_pin_i, 4'h0};
		state_next.a_sync2 = state_reg.a_sync1;
		state_next.b_sync2 = state_reg.b_sync1;
		state_next.a_prev = state_reg.a_sync2;
		state_next.b_prev = state_reg.b_sync2;
		// Detection ignores master enable
		a_hit = edge_hits(state_reg.a_sync2, state_reg.a_prev, state_reg.a_rise,
			state_reg.a_fall) & PORT_A_MASK;
		b_hit = edge_hits(state_reg.b_sync2, state_reg.b_prev, state_reg.b_rise,
			state_reg.b_fall) & PORT_B_MASK;
		// Register writes, unimplemented bits dropped
		if (bus.wr) begin
			case (bus.addr)
				ADDR_A_RISE: state_next.a_rise = bus.wdata & PORT_A_MASK;
				ADDR_A_FALL: state_next.a_fall = bus.wdata & PORT_A_MASK;
				ADDR_A_FLAG: state_next.a_flag = bus.wdata & state_reg.a_flag;
				ADDR_B_RISE: state_next.b_rise = bus.wdata & PORT_B_MASK;
				ADDR_B_FALL: state_next.b_fall = bus.wdata & PORT_B_MASK;
				ADDR_B_FLAG: state_next.b_flag = bus.wdata & state_reg.b_flag;
				ADDR_CTRL: state_next.master_en = bus.wdata[CTRL_MASTER_EN_BIT];
				ADDR_STATUS: state_next.status = state_reg.status & ~bus.wdata[STAT_WIDTH-1:0];
				ADDR_MASK: state_next.mask = bus.wdata[STAT_WIDTH-1:0];
				default: state_next.rdata = state_reg.rdata;
			endcase
		end
		// Hardware set wins over a clearing write
		state_next.a_flag = state_next.a_flag | a_hit;
		state_next.b_flag = state_next.b_flag | b_hit;
		state_next.status[STAT_A_BIT] = state_next.status[STAT_A_BIT] | (|a_hit);
		state_next.status[STAT_B_BIT] = state_next.status[STAT_B_BIT] | (|b_hit);
		// Read data, one cycle after the strobe; unmapped reads zero
		state_next.rdata = ZERO_BYTE;
		if (bus.rd) begin
			case (bus.addr)
				ADDR_A_RISE: state_next.rdata = state_reg.a_rise;
				ADDR_A_FALL: state_next.rdata = state_reg.a_fall;
				ADDR_A_FLAG: state_next.rdata = state_reg.a_flag;
				ADDR_B_RISE: state_next.rdata = state_reg.b_rise;
				ADDR_B_FALL: state_next.rdata = state_reg.b_fall;
				ADDR_B_FLAG: state_next.rdata = state_reg.b_flag;
				ADDR_CTRL: begin
					state_next.rdata[CTRL_MASTER_EN_BIT] = state_reg.master_en;
					state_next.rdata[CTRL_SUMMARY_BIT] = summary;
				end
				ADDR_STATUS: state_next.rdata[STAT_WIDTH-1:0] = state_reg.status;
				ADDR_MASK: state_next.rdata[STAT_WIDTH-1:0] = state_reg.mask;
				default: state_next.rdata = ZERO_BYTE;
			endcase
		end
	end

	//------------------------------------------------------------
	// State register, synchronous active-low reset
	//------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Summary flag and gated request
	assign summary = |{state_reg.a_flag, state_reg.b_flag};
	assign change_irq_o = summary & state_reg.master_en;
	assign wake_o = change_irq_o;
	assign irq_o = |(state_reg.status & state_reg.mask);
	assign rdata_o = state_reg.rdata;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_a_rise;
		state_reg.a_rise[0] && state_reg.a_sync2[0] && !state_reg.a_prev[0];
	endsequence
	property p_a_rise_sets;
		s_a_rise |=> state_reg.a_flag[0];
	endproperty
	a_a_rise_sets: assert property (p_a_rise_sets) else $error("rise flag missed");
	property p_b_fall_sets;
		state_reg.b_fall[4] && !state_reg.b_sync2[4] && state_reg.b_prev[4]
			|=> state_reg.b_flag[4];
	endproperty
	a_b_fall_sets: assert property (p_b_fall_sets) else $error("fall flag missed");
	property p_flag_sticky;
		state_reg.a_flag[1] && !(bus.wr && bus.addr == ADDR_A_FLAG) |=> state_reg.a_flag[1];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
	property p_a_unimpl;
		((state_reg.a_rise | state_reg.a_fall | state_reg.a_flag) & ~PORT_A_MASK) == ZERO_BYTE;
	endproperty
	a_a_unimpl: assert property (p_a_unimpl) else $error("port A upper bits set");
	property p_b_unimpl;
		((state_reg.b_rise | state_reg.b_fall | state_reg.b_flag) & ~PORT_B_MASK) == ZERO_BYTE;
	endproperty
	a_b_unimpl: assert property (p_b_unimpl) else $error("port B lower bits set");
	property p_set_wins;
		s_a_rise ##0 (bus.wr && bus.addr == ADDR_A_FLAG) |=> state_reg.a_flag[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");
	property p_irq_gate;
		change_irq_o == (summary && state_reg.master_en);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("gate wrong");
	property p_sync_delay;
		port_a_pin_i[2] ##1 port_a_pin_i[2] |=> state_reg.a_sync2[2];
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");
	property p_read_one;
		bus.rd && bus.addr == ADDR_A_RISE |=> rdata_o == $past(state_reg.a_rise);
	endproperty
	a_read_one: assert property (p_read_one) else $error("read data wrong");

	//------------------------------------------------------------
	// Further checks on edges, flags, interrupt and register port
	//------------------------------------------------------------
	// Armed falling edge on port A pin 0
	sequence s_a_fall;
		state_reg.a_fall[0] && !state_reg.a_sync2[0] && state_reg.a_prev[0];
	endsequence

	// Armed rising edge on port B pin 4
	sequence s_b_rise;
		state_reg.b_rise[4] && state_reg.b_sync2[4] && !state_reg.b_prev[4];
	endsequence

	// Software write to the port B flag register
	sequence s_b_flag_wr;
		bus.wr && bus.addr == ADDR_B_FLAG;
	endsequence

	// Falling edge sets the port A flag
	property p_a_fall_sets;
		s_a_fall |=> state_reg.a_flag[0];
	endproperty
	a_a_fall_sets: assert property (p_a_fall_sets) else $error("fall flag missed");

	// Rising edge sets the port B flag
	property p_b_rise_sets;
		s_b_rise |=> state_reg.b_flag[4];
	endproperty
	a_b_rise_sets: assert property (p_b_rise_sets) else $error("rise flag missed");

	// Both enables: any change flags the pin
	property p_both_edges;
		state_reg.a_rise[1] && state_reg.a_fall[1] && (state_reg.a_sync2[1] != state_reg.a_prev[1])
			|=> state_reg.a_flag[1];
	endproperty
	a_both_edges: assert property (p_both_edges) else $error("either edge missed");

	// Port B flag holds without a clearing write
	property p_b_sticky;
		state_reg.b_flag[7] && !(bus.wr && bus.addr == ADDR_B_FLAG) |=> state_reg.b_flag[7];
	endproperty
	a_b_sticky: assert property (p_b_sticky) else $error("port B flag dropped");

	// Flag never rises without an armed edge
	property p_no_spurious;
		!state_reg.a_flag[0] && !(state_reg.a_rise[0] && state_reg.a_sync2[0] && !state_reg.a_prev[0])
			&& !(state_reg.a_fall[0] && !state_reg.a_sync2[0] && state_reg.a_prev[0])
			|=> !state_reg.a_flag[0];
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

	// Summary bit read back as OR of flags
	property p_summary_or;
		bus.rd && bus.addr == ADDR_CTRL |=> rdata_o[CTRL_SUMMARY_BIT] ==
			($past(state_reg.a_flag) != ZERO_BYTE || $past(state_reg.b_flag) != ZERO_BYTE);
	endproperty
	a_summary_or: assert property (p_summary_or) else $error("summary bit wrong");

	// Wake request follows the change request
	property p_wake_follows;
		wake_o == change_irq_o;
	endproperty
	a_wake_follows: assert property (p_wake_follows) else $error("wake wrong");

	// Enabled and flagged gives a request
	property p_irq_when_flag;
		state_reg.master_en && (state_reg.a_flag != ZERO_BYTE) |-> change_irq_o;
	endproperty
	a_irq_when_flag: assert property (p_irq_when_flag) else $error("request missing");

	// Master enable clear blocks the request
	property p_no_irq_off;
		!state_reg.master_en |-> !change_irq_o;
	endproperty
	a_no_irq_off: assert property (p_no_irq_off) else $error("request while off");

	// Detection goes on with master enable clear
	property p_detect_off;
		!state_reg.master_en ##0 s_a_rise |=> state_reg.a_flag[0];
	endproperty
	a_detect_off: assert property (p_detect_off) else $error("detect stopped");

	// Port A event marks status bit
	property p_status_a;
		(a_hit != ZERO_BYTE) |=> state_reg.status[STAT_A_BIT];
	endproperty
	a_status_a: assert property (p_status_a) else $error("status A missed");

	// Port B event marks status bit
	property p_status_b;
		(b_hit != ZERO_BYTE) |=> state_reg.status[STAT_B_BIT];
	endproperty
	a_status_b: assert property (p_status_b) else $error("status B missed");

	// Unmasked status raises the interrupt
	property p_irq_level;
		state_reg.status[STAT_A_BIT] && state_reg.mask[STAT_A_BIT] |-> irq_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq missing");

	// Read data zero outside the read answer
	property p_rdata_idle;
		!bus.rd |=> rdata_o == ZERO_BYTE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

	// Unmapped index reads zero
	property p_unmapped_read;
		bus.rd && bus.addr > ADDR_MASK |=> rdata_o == ZERO_BYTE;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

	// Port A rise enable keeps implemented bits
	property p_a_rise_wr;
		bus.wr && bus.addr == ADDR_A_RISE |=> state_reg.a_rise == ($past(wdata_i) & PORT_A_MASK);
	endproperty
	a_a_rise_wr: assert property (p_a_rise_wr) else $error("A rise write wrong");

	// Port A fall enable keeps implemented bits
	property p_a_fall_wr;
		bus.wr && bus.addr == ADDR_A_FALL |=> state_reg.a_fall == ($past(wdata_i) & PORT_A_MASK);
	endproperty
	a_a_fall_wr: assert property (p_a_fall_wr) else $error("A fall write wrong");

	// Port B rise enable keeps implemented bits
	property p_b_rise_wr;
		bus.wr && bus.addr == ADDR_B_RISE |=> state_reg.b_rise == ($past(wdata_i) & PORT_B_MASK);
	endproperty
	a_b_rise_wr: assert property (p_b_rise_wr) else $error("B rise write wrong");

	// Port B fall enable keeps implemented bits
	property p_b_fall_wr;
		bus.wr && bus.addr == ADDR_B_FALL |=> state_reg.b_fall == ($past(wdata_i) & PORT_B_MASK);
	endproperty
	a_b_fall_wr: assert property (p_b_fall_wr) else $error("B fall write wrong");

	// First stage takes the pin level
	property p_sync_first;
		1'b1 |=> state_reg.a_sync1[5:0] == $past(port_a_pin_i);
	endproperty
	a_sync_first: assert property (p_sync_first) else $error("first stage wrong");

	// Second stage reads only the first
	property p_b_sync_chain;
		1'b1 |=> state_reg.b_sync2 == $past(state_reg.b_sync1);
	endproperty
	a_b_sync_chain: assert property (p_b_sync_chain) else $error("second stage wrong");

	// Reset clears both flag registers and the port A rise enable
	property p_reset_zero;
		disable iff (1'b0) !nrst_i |=> state_reg.a_flag == ZERO_BYTE
			&& state_reg.b_flag == ZERO_BYTE && state_reg.a_rise == ZERO_BYTE;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");

	// Write one clears a quiet status bit
	property p_status_w1c;
		bus.wr && bus.addr == ADDR_STATUS && bus.wdata[STAT_A_BIT] && (a_hit == ZERO_BYTE)
			|=> !state_reg.status[STAT_A_BIT];
	endproperty
	a_status_w1c: assert property (p_status_w1c) else $error("status not cleared");

	// Port B edge beats a clearing write
	property p_set_wins_b;
		s_b_rise ##0 s_b_flag_wr |=> state_reg.b_flag[4];
	endproperty
	a_set_wins_b: assert property (p_set_wins_b) else $error("B clear beat set");

	// Edge while enabled: flag and wake together
	property p_sleep_record;
		s_a_rise ##0 state_reg.master_en |=> state_reg.a_flag[0] && wake_o;
	endproperty
	a_sleep_record: assert property (p_sleep_record) else $error("wake flag missing");
endmodule

// ==== design/pceirq_pkg.sv ====
// Package: constants, register map and state carrier for the pin change interrupt block
//------------------------------------------------------------
// Functional notes
// - Master enable lets pin edges wake from sleep
// - Sleep edges recorded before first wake fetch
// - Port A rise enables bits 5:0, rest zero
// - Port A fall enables bits 5:0, rest zero
// - Port A flag set on enabled edge
// - Flags sticky; hardware sets, software clears
// - Port B rise enables bits 7:4, rest zero
// - Port B fall enables bits 7:4, rest zero
// - Port B flag set on enabled edge
// - Detection continues while master enable clear
// - Summary flag is OR of all flags
// - Edge during clear write leaves flag set
// - Both enables set flag on either edge
//------------------------------------------------------------
package pceirq_pkg;
	// Register indices on the plain port
	localparam logic [3:0] ADDR_A_RISE = 4'h0;
	localparam logic [3:0] ADDR_A_FALL = 4'h1;
	localparam logic [3:0] ADDR_A_FLAG = 4'h2;
	localparam logic [3:0] ADDR_B_RISE = 4'h3;
	localparam logic [3:0] ADDR_B_FALL = 4'h4;
	localparam logic [3:0] ADDR_B_FLAG = 4'h5;
	localparam logic [3:0] ADDR_CTRL = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	localparam logic [3:0] ADDR_MASK = 4'h8;
	// Implemented bit masks
	localparam logic [7:0] PORT_A_MASK = 8'h3F;
	localparam logic [7:0] PORT_B_MASK = 8'hF0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Control register fields
	localparam int CTRL_MASTER_EN_BIT = 0;
	localparam int CTRL_SUMMARY_BIT = 1;
	// Status register fields (events)
	localparam int STAT_A_BIT = 0;
	localparam int STAT_B_BIT = 1;
	localparam int STAT_WIDTH = 2;
	// Bus request carrier
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pceirq_bus_type;
	// Whole block state
	typedef struct packed {
		logic [7:0] a_sync1;
		logic [7:0] a_sync2;
		logic [7:0] a_prev;
		logic [7:0] b_sync1;
		logic [7:0] b_sync2;
		logic [7:0] b_prev;
		logic [7:0] a_rise;
		logic [7:0] a_fall;
		logic [7:0] a_flag;
		logic [7:0] b_rise;
		logic [7:0] b_fall;
		logic [7:0] b_flag;
		logic master_en;
		logic [STAT_WIDTH-1:0] status;
		logic [STAT_WIDTH-1:0] mask;
		logic [7:0] rdata;
	} pceirq_state_type;
endpackage

// ==== dv/pceirq_pins.sv ====
// Model of the external signals on the monitored port pins
module pceirq_pins (
	// Clock
	input wire logic clk_i,
	// Pin levels
	output logic [5:0] a_o,
	output logic [7:4] b_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins start low
	initial begin
		a_o = 6'h00;
		b_o = 4'h0;
	end
	// New levels just after an edge, held until the next call
	task automatic put(input logic [5:0] a, input logic [7:4] b);
		@(posedge clk_i);
		a_o <= a;
		b_o <= b;
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the pin change interrupt block
module tb_top import pceirq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i, nrst_i, wr_i, rd_i, change_irq_o, wake_o, irq_o;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o;
	logic [5:0] pa;
	logic [7:4] pb;
	int n_mismatch = 0;
	int cmp_count = 0;
	//----------------------------------------
	// Clock, design and pins
	//----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	pceirq_top dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .port_a_pin_i(pa),
		.port_b_pin_i(pb), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .change_irq_o(change_irq_o), .wake_o(wake_o), .irq_o(irq_o));
	pceirq_pins pins_u (.clk_i(core_clk_i), .a_o(pa), .b_o(pb));
	//----------------------------------------
	// Tasks
	//----------------------------------------
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle write
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, e, rdata_o);
	endtask
	// Pins change, then let the synchroniser settle
	task automatic pins(input logic [5:0] a, input logic [7:4] b);
		pins_u.put(a, b);
		repeat (4) @(posedge core_clk_i);
	endtask
	// Verdict
	task automatic end_of_test();
		$display("Counts: mismatches %0d, compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#50000;
		n_mismatch++;
		end_of_test();
	end
	//----------------------------------------
	// Tests
	//----------------------------------------
	initial begin
		nrst_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		// All registers and an unmapped place read zero
		for (int i = 0; i < 10; i++) rd(i[3:0], 8'h00, "reset");
		wr(ADDR_A_RISE, 8'hFF);
		wr(ADDR_B_RISE, 8'hFF);
		rd(ADDR_A_RISE, PORT_A_MASK, "a_rise");
		rd(ADDR_B_RISE, PORT_B_MASK, "b_rise");
		pins(6'h3F, 4'hF);
		rd(ADDR_A_FLAG, 8'h3F, "a_flag");
		rd(ADDR_B_FLAG, 8'hF0, "b_flag");
		chk("irq off", 8'h00, {6'h00, change_irq_o, wake_o});
		wr(ADDR_A_FLAG, 8'h00);
		wr(ADDR_B_FLAG, 8'h00);
		// Falling edges not armed yet
		pins(6'h00, 4'h0);
		rd(ADDR_A_FLAG, 8'h00, "a_flag");
		rd(ADDR_B_FLAG, 8'h00, "b_flag");
		wr(ADDR_A_FALL, 8'hFF);
		wr(ADDR_B_FALL, 8'hFF);
		rd(ADDR_A_FALL, PORT_A_MASK, "a_fall");
		rd(ADDR_B_FALL, PORT_B_MASK, "b_fall");
		wr(ADDR_CTRL, 8'h01);
		pins(6'h3F, 4'hF);
		chk("irq on", 8'h03, {6'h00, change_irq_o, wake_o});
		rd(ADDR_CTRL, 8'h03, "ctrl");
		// Clear by complement of the value seen
		wr(ADDR_A_FLAG, 8'h3F ^ 8'hFF);
		wr(ADDR_B_FLAG, 8'hF0 ^ 8'hFF);
		rd(ADDR_A_FLAG, 8'h00, "a_flag");
		rd(ADDR_CTRL, 8'h01, "ctrl");
		chk("irq clr", 8'h00, {7'h00, change_irq_o});
		pins(6'h00, 4'h0);
		rd(ADDR_A_FLAG, 8'h3F, "a_flag");
		rd(ADDR_B_FLAG, 8'hF0, "b_flag");
		// Edge lands while a clear is written
		pins_u.put(6'h3F, 4'hF);
		@(posedge core_clk_i);
		wr(ADDR_A_FLAG, 8'h00);
		rd(ADDR_A_FLAG, 8'h3F, "a_flag");
		// Event status, mask and interrupt
		rd(ADDR_STATUS, 8'h03, "status");
		wr(ADDR_MASK, 8'h03);
		#1 chk("irq_o", 8'h01, {7'h00, irq_o});
		wr(ADDR_MASK, 8'h00);
		#1 chk("irq_o", 8'h00, {7'h00, irq_o});
		wr(ADDR_STATUS, 8'h03);
		rd(ADDR_STATUS, 8'h00, "status");
		end_of_test();
	end
endmodule
